/* File: rtl/sad_pkg.sv */
package sad_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int SLOT_BITS = 12;
  localparam int NTGT = 25;

  // transfer sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // region bounds
  localparam logic [31:0] FLASH_LO = 32'h0000_0000;
  localparam logic [31:0] FLASH_HI = 32'h0000_3FFF;
  localparam logic [31:0] SRAM_LO = 32'h2000_0000;
  localparam logic [31:0] SRAM_HI = 32'h2000_0FFF;
  localparam logic [31:0] SRAM_BB_LO = 32'h2200_0000;
  localparam logic [31:0] SRAM_BB_HI = 32'h2201_FFFF;
  localparam logic [31:0] PERI_LO = 32'h4000_0000;
  localparam logic [31:0] PERI_HI = 32'h400F_FFFF;
  localparam logic [31:0] PERI_BB_LO = 32'h4200_0000;
  localparam logic [31:0] PERI_BB_HI = 32'h43FF_FFFF;
  localparam logic [31:0] PRIV_BUS_LO = 32'hE000_0000;
  localparam logic [31:0] PRIV_BUS_HI = 32'hE00F_FFFF;
  // alias word offset bits that name the target word and bit
  localparam int BB_WORD_LSB = 7;
  localparam int BB_BIT_LSB = 2;
  localparam int BB_SPAN_MSB = 24;

  // target indices
  localparam int T_FLASH = 0;
  localparam int T_SRAM = 1;
  localparam int T_WDOG0 = 2;
  localparam int T_GPIOA = 3;
  localparam int T_GPIOB = 4;
  localparam int T_GPIOC = 5;
  localparam int T_GPIOD = 6;
  localparam int T_SSP0 = 7;
  localparam int T_UART0 = 8;
  localparam int T_UART1 = 9;
  localparam int T_GPIOE = 10;
  localparam int T_PWM = 11;
  localparam int T_TIMER0 = 12;
  localparam int T_TIMER1 = 13;
  localparam int T_TIMER2 = 14;
  localparam int T_ADC0 = 15;
  localparam int T_ACMP = 16;
  localparam int T_FLASHCTL = 17;
  localparam int T_SYSCTL = 18;
  localparam int T_TRACE_MC = 19;
  localparam int T_WATCH_TU = 20;
  localparam int T_PATCH_BU = 21;
  localparam int T_CORE_PERI = 22;
  localparam int T_TRACE_PU = 23;
  localparam int T_NONE = 24;

  // 4 kB slot bases of single-slot targets, indexed by target number 2..23
  localparam logic [31:0] SLOT_BASE [NTGT] = '{
    32'h0000_0000, 32'h0000_0000,
    32'h4000_0000, 32'h4000_4000, 32'h4000_5000, 32'h4000_6000, 32'h4000_7000,
    32'h4000_8000, 32'h4000_C000, 32'h4000_D000, 32'h4002_4000, 32'h4002_8000,
    32'h4003_0000, 32'h4003_1000, 32'h4003_2000, 32'h4003_8000, 32'h4003_C000,
    32'h400F_D000, 32'h400F_E000, 32'hE000_0000, 32'hE000_1000, 32'hE000_2000,
    32'hE000_E000, 32'hE004_0000, 32'h0000_0000
  };
  localparam int FIRST_SLOT = 2;
  localparam int LAST_SLOT = 23;
  localparam int FIRST_NOEXEC_SLOT = 2;

  typedef enum logic [4:0] {
    SAD_IDLE = 5'h01,
    SAD_READ = 5'h02,
    SAD_MODIFY = 5'h04,
    SAD_WRITE = 5'h08,
    SAD_RESP = 5'h10
  } sad_state_e;
endpackage

/* File: rtl/sad_region_map.sv */
`timescale 1ns/1ns
// pure address to target decode, one-hot select plus fault
module sad_region_map #(
  parameter int NTGT = sad_pkg::NTGT
) (
  input wire logic [31:0] addr,
  input wire logic fetch,
  output logic [NTGT-1:0] sel,
  output logic is_sram_bb,
  output logic is_peri_bb,
  output logic fault
);
  logic [NTGT-1:0] hit;
  wire in_flash = addr <= sad_pkg::FLASH_HI;
  wire in_sram = addr >= sad_pkg::SRAM_LO && addr <= sad_pkg::SRAM_HI;
  wire in_peri = addr >= sad_pkg::PERI_LO && addr <= sad_pkg::PERI_HI;
  wire in_priv_bus = addr >= sad_pkg::PRIV_BUS_LO && addr <= sad_pkg::PRIV_BUS_HI;
  wire no_exec_region = in_peri || in_priv_bus ||
    (addr >= sad_pkg::PERI_BB_LO && addr <= sad_pkg::PERI_BB_HI);

  genvar g;
  generate
    for (g = 0; g < NTGT; g++)
    begin : g_hit
      if (g == sad_pkg::T_FLASH)
      begin : g_f
        assign hit[g] = in_flash;
      end
      else if (g == sad_pkg::T_SRAM)
      begin : g_s
        assign hit[g] = in_sram;
      end
      else if (g == sad_pkg::T_NONE)
      begin : g_n
        assign hit[g] = 1'b0;
      end
      else
      begin : g_slot
        // one 4 kB slot per target; private bus slots only hold core blocks
        assign hit[g] = addr[31:sad_pkg::SLOT_BITS] ==
          sad_pkg::SLOT_BASE[g][31:sad_pkg::SLOT_BITS];
      end
    end
  endgenerate

  assign is_sram_bb = addr >= sad_pkg::SRAM_BB_LO && addr <= sad_pkg::SRAM_BB_HI;
  assign is_peri_bb = addr >= sad_pkg::PERI_BB_LO && addr <= sad_pkg::PERI_BB_HI;
  // fetches from execute-never space are blocked and fault
  wire no_exec_block = fetch && no_exec_region;
  wire any_hit = (|hit) || is_sram_bb || is_peri_bb;
  assign fault = !any_hit || no_exec_block;
  assign sel = (fault || is_sram_bb || is_peri_bb) ? '0 : hit;
endmodule

/* File: rtl/sad_decoder.sv */
`timescale 1ns/1ns
// Contract
// - fixed 4 GB map, not reprogrammable
// - reserved space faults, selects nothing
// - sram alias window maps single sram bits
// - peripheral alias window maps single bits
// - alias read-modify-write is locked, atomic
// - little-endian byte order throughout
// - byte, halfword, word; size 3 is handled as a word
// - peripherals get slot offset address
// - private bus debug slots routed to trace blocks
// - core peripheral block at 0xE000E000
// - trace port slot; other private bus faults
// - private bus holds debug, trace port and core peripheral slots
// - execute-never regions block instruction fetch
module sad_decoder #(
  parameter int NTGT = sad_pkg::NTGT
) (
  input wire logic mclk,
  input wire logic arst_n,
  // master side
  input wire logic m_req,
  input wire logic m_write,
  input wire logic m_fetch,
  input wire logic [1:0] m_size,
  input wire logic [31:0] m_addr,
  input wire logic [31:0] m_wdata,
  output logic m_ready,
  output logic m_done,
  output logic m_fault,
  output logic [31:0] m_rdata,
  // target side
  output logic [NTGT-1:0] t_sel,
  output logic t_write,
  output logic [31:0] t_addr,
  output logic [3:0] t_strb,
  output logic [31:0] t_wdata,
  output logic t_lock,
  input wire logic t_done,
  input wire logic [31:0] t_rdata
);
  sad_pkg::sad_state_e state;
  sad_pkg::sad_state_e next_state;

  logic [NTGT-1:0] dec_sel;
  logic dec_sram_bb;
  logic dec_peri_bb;
  logic dec_fault;

  sad_region_map #(
    .NTGT(NTGT)
  ) u_map (
    .addr(m_addr),
    .fetch(m_fetch),
    .sel(dec_sel),
    .is_sram_bb(dec_sram_bb),
    .is_peri_bb(dec_peri_bb),
    .fault(dec_fault)
  );

  // the map is constants only; nothing can move a range
  wire idle = state == sad_pkg::SAD_IDLE;
  assign m_ready = idle;
  wire take = idle && m_req;

  // alias address: word offset selects the target word, low bits the bit
  wire [31:0] bb_off = m_addr - (dec_sram_bb ? sad_pkg::SRAM_BB_LO : sad_pkg::PERI_BB_LO);
  wire [4:0] bb_bit = bb_off[sad_pkg::BB_WORD_LSB-1:sad_pkg::BB_BIT_LSB];
  localparam int BB_PAD = sad_pkg::ADDR_W - 1 - sad_pkg::BB_SPAN_MSB + sad_pkg::BB_WORD_LSB -
    sad_pkg::BB_BIT_LSB;
  wire [31:0] bb_word_off = {{BB_PAD{1'b0}}, bb_off[sad_pkg::BB_SPAN_MSB:sad_pkg::BB_WORD_LSB],
    {sad_pkg::BB_BIT_LSB{1'b0}}};
  wire [31:0] bb_target = (dec_sram_bb ? sad_pkg::SRAM_LO : sad_pkg::PERI_LO)
    + bb_word_off;
  wire is_bb = dec_sram_bb || dec_peri_bb;

  // alias target select reuses the region map on the target word address
  logic [NTGT-1:0] bb_sel;
  logic bb_fault;
  sad_region_map #(
    .NTGT(NTGT)
  ) u_bbmap (
    .addr(bb_target),
    .fetch(1'b0),
    .sel(bb_sel),
    .is_sram_bb(),
    .is_peri_bb(),
    .fault(bb_fault)
  );

  // byte lanes, little endian: lowest address in lowest lane
  wire [3:0] strb_sel;
  wire [31:0] wdata_lane;
  genvar b;
  generate
    for (b = 0; b < 4; b++)
    begin : g_lane
      // a lane is hit by its own byte, its half of the word, or any word access
      wire byte_hit = m_addr[1:0] == 2'(b);
      wire half_hit = m_addr[1] == ((b / 2) == 1);
      assign strb_sel[b] = (m_size == sad_pkg::SIZE_BYTE) ? byte_hit :
        (m_size == sad_pkg::SIZE_HALF) ? half_hit : 1'b1;
      // narrow data is copied onto every lane it may land in
      assign wdata_lane[8*b+:8] = (m_size == sad_pkg::SIZE_BYTE) ? m_wdata[7:0] :
        (m_size == sad_pkg::SIZE_HALF) ? m_wdata[8*(b%2)+:8] : m_wdata[8*b+:8];
    end
  endgenerate

  // slot-relative address for slotted peripherals
  logic slot_hit;
  logic [31:0] slot_off;
  always_comb
  begin
    slot_hit = 1'b0;
    slot_off = m_addr;
    for (int i = sad_pkg::FIRST_SLOT; i <= sad_pkg::LAST_SLOT; i++)
    begin
      if (dec_sel[i])
      begin
        slot_hit = 1'b1;
        slot_off = {20'h0_0000, m_addr[sad_pkg::SLOT_BITS-1:0]};
      end
    end
  end

  // held access
  logic bb_val;
  logic [4:0] bb_bit_q;
  logic bb_wr;
  logic [31:0] word_q;

  wire rd_done = t_done;
  wire [31:0] modified = bb_val ? (word_q | (32'h0000_0001 << bb_bit_q))
    : (word_q & ~(32'h0000_0001 << bb_bit_q));

  always_comb
  begin
    next_state = state;
    case (state)
      sad_pkg::SAD_IDLE:
      begin
        if (take)
        begin
          if (dec_fault || (is_bb && bb_fault))
            next_state = sad_pkg::SAD_RESP;
          else if (is_bb)
            next_state = sad_pkg::SAD_READ;
          else
            next_state = sad_pkg::SAD_WRITE;
        end
      end
      sad_pkg::SAD_READ:
      begin
        if (rd_done)
          next_state = bb_wr ? sad_pkg::SAD_MODIFY : sad_pkg::SAD_RESP;
      end
      sad_pkg::SAD_MODIFY:
        next_state = sad_pkg::SAD_WRITE;
      sad_pkg::SAD_WRITE:
      begin
        if (t_done)
          next_state = sad_pkg::SAD_RESP;
      end
      sad_pkg::SAD_RESP:
        next_state = sad_pkg::SAD_IDLE;
      default:
        next_state = sad_pkg::SAD_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      state <= sad_pkg::SAD_IDLE;
    else
      state <= next_state;
  end

  // captured request and target drive
  wire fault_now = dec_fault || (is_bb && bb_fault);
  wire grant = take && !fault_now;
  wire grant_bb = grant && is_bb;
  wire grant_plain = grant && !is_bb;
  wire in_read = state == sad_pkg::SAD_READ;
  wire in_modify = state == sad_pkg::SAD_MODIFY;
  wire in_write = state == sad_pkg::SAD_WRITE;
  // the select drops after the last completion, never between the two halves
  wire last_done = (in_write && t_done) || (in_read && rd_done && !bb_wr);

  // an alias into a peripheral slot hands over only the slot offset
  wire bb_slot_hit = |bb_sel[sad_pkg::LAST_SLOT:sad_pkg::FIRST_SLOT];
  wire [31:0] bb_taddr = bb_slot_hit ?
    {20'h0_0000, bb_target[sad_pkg::SLOT_BITS-1:0]} : bb_target;
  wire [31:0] plain_taddr = slot_hit ? slot_off : m_addr;

  wire [NTGT-1:0] grant_sel = is_bb ? bb_sel : dec_sel;
  wire [NTGT-1:0] next_t_sel = grant ? grant_sel : (last_done ? '0 : t_sel);
  // alias: read first, the modify cycle turns the same select into a write
  wire next_t_write = grant ? (!is_bb && m_write) :
    (in_modify ? 1'b1 : (last_done ? 1'b0 : t_write));
  wire next_t_lock = grant ? is_bb : (last_done ? 1'b0 : t_lock);
  wire [31:0] next_t_addr = grant ? (is_bb ? bb_taddr : plain_taddr) : t_addr;
  wire [3:0] next_t_strb = grant ? (is_bb ? 4'hF : strb_sel) : t_strb;
  wire [31:0] next_t_wdata = grant_plain ? wdata_lane : (in_modify ? modified : t_wdata);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      t_sel <= '0;
    else
      t_sel <= next_t_sel;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      t_write <= 1'b0;
    else
      t_write <= next_t_write;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      t_lock <= 1'b0;
    else
      t_lock <= next_t_lock;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      t_addr <= 32'h0000_0000;
      t_strb <= 4'h0;
      t_wdata <= 32'h0000_0000;
    end
    else
    begin
      t_addr <= next_t_addr;
      t_strb <= next_t_strb;
      t_wdata <= next_t_wdata;
    end
  end

  // alias bit, value and direction held across the locked sequence
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bb_val <= 1'b0;
      bb_bit_q <= 5'h00;
      bb_wr <= 1'b0;
    end
    else if (grant_bb)
    begin
      bb_val <= m_wdata[0];
      bb_bit_q <= bb_bit;
      bb_wr <= m_write;
    end
  end

  // response to the master
  wire read_back = in_read && rd_done;
  wire plain_back = in_write && t_done && !t_lock;
  wire next_m_fault = take ? fault_now : m_fault;
  wire [31:0] bb_bit_word = {31'h0000_0000, t_rdata[bb_bit_q]};
  wire [31:0] next_m_rdata = read_back ? bb_bit_word :
    (plain_back ? t_rdata : m_rdata);
  wire [31:0] next_word_q = read_back ? t_rdata : word_q;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      m_done <= 1'b0;
    else
      m_done <= state == sad_pkg::SAD_RESP;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      m_fault <= 1'b0;
    else
      m_fault <= next_m_fault;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      m_rdata <= 32'h0000_0000;
    else
      m_rdata <= next_m_rdata;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      word_q <= 32'h0000_0000;
    else
      word_q <= next_word_q;
  end
endmodule

/* File: tb/sad_decoder_assertions.sv */
`timescale 1ns/1ns
module sad_decoder_assertions #(
  parameter int NTGT = 25
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic m_req,
  input wire logic m_write,
  input wire logic m_fetch,
  input wire logic [1:0] m_size,
  input wire logic [31:0] m_addr,
  input wire logic m_ready,
  input wire logic m_done,
  input wire logic m_fault,
  input wire logic [NTGT-1:0] t_sel,
  input wire logic [31:0] t_addr,
  input wire logic [3:0] t_strb,
  input wire logic t_lock
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  wire take = m_req && m_ready;
  sequence fault_resp;
    ##2 (m_done && m_fault);
  endsequence
  sequence locked_read;
    ##1 (t_lock && t_sel[1]);
  endsequence
  a_fault_nosel: assert property (m_done && m_fault |-> $past(t_sel) == 0)
    else $error("faulted access selected a target");
  a_hole_fault: assert property (take && m_addr[31:29] == 0 && m_addr[28:14] != 0 |-> fault_resp)
    else $error("reserved code space did not fault");
  a_noexec_fetch: assert property (take && m_fetch && m_addr[31:29] == 3'h2 |-> fault_resp)
    else $error("peripheral fetch did not fault");
  a_flash_sel: assert property (take && m_addr[31:14] == 0 |=> t_sel == NTGT'(1))
    else $error("flash not selected");
  a_slot_offset: assert property (|t_sel[NTGT-2:2] |-> t_addr[31:12] == 0)
    else $error("slot address not an offset");
  a_trace_port: assert property (take && !m_fetch && m_addr[31:12] == 20'hE0040 |=> t_sel[23])
    else $error("trace port not selected");
  a_byte_lane: assert property (take && m_size == 0 && m_addr[31:12] == 20'h20000
    |=> t_strb == 4'h1 << $past(m_addr[1:0]))
    else $error("byte lane wrong");
  a_alias_lock: assert property (take && m_write && m_addr[31:17] == 15'h1100 |-> locked_read)
    else $error("alias write not locked");
endmodule
bind sad_decoder sad_decoder_assertions #(.NTGT(NTGT)) chk_u (
  .mclk(mclk), .arst_n(arst_n), .m_req(m_req), .m_write(m_write), .m_fetch(m_fetch),
  .m_size(m_size), .m_addr(m_addr), .m_ready(m_ready), .m_done(m_done), .m_fault(m_fault),
  .t_sel(t_sel), .t_addr(t_addr), .t_strb(t_strb), .t_lock(t_lock)
);

/* File: tb/sad_target_model.sv */
`timescale 1ns/1ns
module sad_target_model #(
  parameter int NTGT = 25
) (
  input wire logic mclk,
  input wire logic [NTGT-1:0] t_sel,
  input wire logic t_write,
  input wire logic [31:0] t_addr,
  input wire logic [3:0] t_strb,
  input wire logic [31:0] t_wdata,
  input wire logic [3:0] dly,
  output logic t_done,
  output logic [31:0] t_rdata
);
  logic [31:0] mem [16];
  logic [3:0] cnt;
  initial
  begin
    t_done = 1'h0;
    t_rdata = 32'h0;
    cnt = 4'h0;
    foreach (mem[i]) mem[i] = 32'h0;
  end
  always @(posedge mclk)
  begin
    t_done <= 1'h0;
    t_rdata <= ~t_rdata;
    cnt <= (|t_sel && !t_done) ? cnt + 4'h1 : 4'h0;
    if (|t_sel && !t_done && cnt == dly)
    begin
      t_done <= 1'h1;
      if (t_write)
      begin
        for (int b = 0; b < 4; b++)
          if (t_strb[b]) mem[t_addr[5:2]][8*b+:8] <= t_wdata[8*b+:8];
      end
      else
        t_rdata <= mem[t_addr[5:2]];
    end
  end
endmodule

/* File: tb/system_address_decoder_bench.sv */
`timescale 1ns/1ns
module system_address_decoder_bench;
  localparam int NT = sad_pkg::NTGT;
  localparam logic [31:0] RSV [8] = '{32'h0000_4000, 32'h2000_1000, 32'h2202_0000,
    32'h4000_1000, 32'h4400_0000, 32'hE000_3000, 32'hE004_1000, 32'hFFFF_FFFC};
  logic mclk = 1'h0;
  logic arst_n = 1'h0;
  logic m_req = 1'h0;
  logic m_write = 1'h0;
  logic m_fetch = 1'h0;
  logic [1:0] m_size = 2'h2;
  logic [31:0] m_addr = 32'h0;
  logic [31:0] m_wdata = 32'h0;
  logic [3:0] dly = 4'h2;
  logic m_ready, m_done, m_fault, t_write, t_lock, t_done, s_lock, flt;
  logic [31:0] m_rdata, t_addr, t_wdata, t_rdata, rd, s_addr_q;
  logic [NT-1:0] t_sel, s_sel;
  logic [3:0] t_strb;
  logic [3:0] s_strb;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  always #4 mclk = ~mclk;
  sad_decoder dut_u (.mclk(mclk), .arst_n(arst_n), .m_req(m_req), .m_write(m_write),
    .m_fetch(m_fetch), .m_size(m_size), .m_addr(m_addr), .m_wdata(m_wdata),
    .m_ready(m_ready), .m_done(m_done), .m_fault(m_fault), .m_rdata(m_rdata),
    .t_sel(t_sel), .t_write(t_write), .t_addr(t_addr), .t_strb(t_strb),
    .t_wdata(t_wdata), .t_lock(t_lock), .t_done(t_done), .t_rdata(t_rdata));
  sad_target_model tgt_u (.mclk(mclk), .t_sel(t_sel), .t_write(t_write), .t_addr(t_addr),
    .t_strb(t_strb), .t_wdata(t_wdata), .dly(dly), .t_done(t_done), .t_rdata(t_rdata));
  task summarize;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (|t_sel)
    begin
      s_sel <= t_sel;
      s_addr_q <= t_addr;
      s_strb <= t_strb;
    end
    if (t_lock) s_lock <= 1'h1;
    if (cyc == 20000)
    begin
      errors++;
      summarize();
    end
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task acc(input logic [31:0] a, input logic w, input logic f, input logic [1:0] sz,
    input logic [31:0] d);
    int n;
    n = 0;
    s_sel = '0;
    s_lock = 1'h0;
    {m_addr, m_write, m_fetch, m_size, m_wdata, m_req} = {a, w, f, sz, d, 1'h1};
    @(posedge mclk);
    #1 m_req = 1'h0;
    while (m_done !== 1'h1 && n < 60)
    begin
      @(posedge mclk);
      #1 n++;
    end
    chk("m_done", m_done, 1'h1);
    flt = m_fault;
    rd = m_rdata;
    @(posedge mclk);
    #1;
  endtask
  task t_mem;
    acc(32'h2000_0004, 1'h1, 1'h0, sad_pkg::SIZE_WORD, 32'h1122_3344);
    chk("sram sel", s_sel, NT'(1) << sad_pkg::T_SRAM);
    chk("sram addr", s_addr_q, 32'h2000_0004);
    acc(32'h2000_0005, 1'h1, 1'h0, sad_pkg::SIZE_BYTE, 32'h0000_00AB);
    chk("byte strb", s_strb, 4'h2);
    acc(32'h2000_0006, 1'h1, 1'h0, sad_pkg::SIZE_HALF, 32'h0000_CDEF);
    chk("half strb", s_strb, 4'hC);
    acc(32'h2000_0004, 1'h0, 1'h0, sad_pkg::SIZE_WORD, 32'h0);
    chk("word", rd, 32'hCDEF_AB44);
    acc(32'h0000_3FFC, 1'h0, 1'h1, sad_pkg::SIZE_WORD, 32'h0);
    chk("flash sel", s_sel, NT'(1));
    chk("flash fault", flt, 1'h0);
    $display("memory test done");
  endtask
  task t_fault;
    foreach (RSV[i])
    begin
      acc(RSV[i], i[0], 1'h0, sad_pkg::SIZE_WORD, 32'h0);
      chk("rsv fault", flt, 1'h1);
      chk("rsv sel", s_sel, 32'h0);
    end
    acc(32'h4000_4000, 1'h0, 1'h1, sad_pkg::SIZE_WORD, 32'h0);
    chk("no-exec fault", flt, 1'h1);
    acc(32'hE000_E000, 1'h0, 1'h1, sad_pkg::SIZE_WORD, 32'h0);
    chk("private bus fault", flt, 1'h1);
    $display("fault test done");
  endtask
  task t_slots;
    dly = 4'h5;
    for (int i = sad_pkg::FIRST_SLOT; i <= sad_pkg::LAST_SLOT; i++)
    begin
      acc(sad_pkg::SLOT_BASE[i] + 32'hFFC, 1'h0, 1'h0, sad_pkg::SIZE_WORD, 32'h0);
      chk("slot sel", s_sel, NT'(1) << i);
      chk("slot off", s_addr_q, 32'hFFC);
    end
    dly = 4'h2;
    $display("slot test done");
  endtask
  task t_alias;
    acc(32'h2200_008C, 1'h1, 1'h0, sad_pkg::SIZE_WORD, 32'h1);
    chk("lock", s_lock, 1'h1);
    acc(32'h2000_0004, 1'h0, 1'h0, sad_pkg::SIZE_WORD, 32'h0);
    chk("bit set", rd, 32'hCDEF_AB4C);
    acc(32'h2200_0088, 1'h0, 1'h0, sad_pkg::SIZE_WORD, 32'h0);
    chk("bit read", rd, 32'h1);
    acc(32'h2200_008C, 1'h1, 1'h0, sad_pkg::SIZE_WORD, 32'h0);
    acc(32'h2200_008C, 1'h0, 1'h0, sad_pkg::SIZE_WORD, 32'h0);
    chk("bit clr", rd, 32'h0);
    acc(32'h4208_0014, 1'h1, 1'h0, sad_pkg::SIZE_WORD, 32'h1);
    acc(32'h4208_0014, 1'h0, 1'h0, sad_pkg::SIZE_WORD, 32'h0);
    chk("peri bit", rd, 32'h1);
    chk("peri sel", s_sel, NT'(1) << sad_pkg::T_GPIOA);
    chk("peri off", s_addr_q, 32'h0);
    acc(32'h4202_0000, 1'h0, 1'h0, sad_pkg::SIZE_WORD, 32'h0);
    chk("alias rsv fault", flt, 1'h1);
    chk("alias rsv sel", s_sel, 32'h0);
    $display("alias test done");
  endtask
  initial
  begin
    repeat (20) @(posedge mclk);
    #1 arst_n = 1'h1;
    t_mem();
    t_fault();
    t_slots();
    t_alias();
    summarize();
  end
endmodule
